// ### design/fsc_regs.vh
// constants for the flash status and configuration register set
// Functional notes
// - paused flag reads at status byte two bit 7
// - invert bit flips the selected protect region
// - three lock bits, zero unprotected, one protected
// - four-lane enable turns guard/pause pins into lanes
// - pin function: pause at 0, reset at 1
// - two volatile strength bits, byte three 6:5
// - fast precharge mode bit at byte three 4
// - busy set during program, erase, non-volatile status write
// - while busy ignore all but status read
// - busy clears when operation completes
// - write enable sets write latch bit
// - write latch cleared by disable, program, erase, non-volatile write
// - three range bits at byte one 4:2
// - end select: top at 0, bottom at 1
// - end select written only when lock mode and write latch or volatile enable allow
// - granularity: sectors at 1, blocks at 0
// - suspend sets paused flag, resume clears it
// - volatile enable then write updates volatile copies
// - lock mode with guard low rejects byte one, two writes unless four-lane enable is set
// - latch set only by enable, cleared on completion
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
`define FSC_CMD_WREN 8'h06
`define FSC_CMD_WRDI 8'h04
`define FSC_CMD_VWREN 8'h50
`define FSC_CMD_WRSR1 8'h01
`define FSC_CMD_WRSR2 8'h31
`define FSC_CMD_WRSR3 8'h11
`define FSC_CMD_RDSR1 8'h05
`define FSC_CMD_RDSR2 8'h35
`define FSC_CMD_RDSR3 8'h15
`define FSC_CMD_PP 8'h02
`define FSC_CMD_SE 8'h20
`define FSC_CMD_BE 8'hD8
`define FSC_CMD_CE 8'hC7
`define FSC_CMD_SUSP 8'h75
`define FSC_CMD_RESUME 8'h7A
`define FSC_SR1_WMASK 8'hFC
`define FSC_SR2_WMASK 8'h7A
`define FSC_SR3_WMASK 8'hF0
`define FSC_SR2_LOCK_MASK 8'h38
`define FSC_B1_LOCKMODE 7
`define FSC_B1_GRAN 6
`define FSC_B1_ENDSEL 5
`define FSC_B1_WEL 1
`define FSC_B1_BUSY 0
`define FSC_B2_PAUSED 7
`define FSC_B2_INVERT 6
`define FSC_B2_QUAD 1
`define FSC_B3_PINFN 7
`define FSC_B3_HFM 4
`define FSC_RESET_VAL 8'h00
`define FSC_NV_WRITE_NS 5000
`define FSC_CLK_NS 10
// 5000 ns at the 10 ns clock, sized to match the 16-bit timer load
`define FSC_NV_WRITE_CYC 16'h01F4
`endif

// ### design/fsc_busy_timer.v
// busy countdown for embedded operations
`timescale 1ns/10ps
`default_nettype none
module fsc_busy_timer (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // operation start with its length
  input wire start,
  input wire [15:0] cycles,
  // busy level and completion pulse
  output reg busy_q,
  output reg done_q
);
  reg [15:0] count_q;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      count_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        count_q <= cycles;
      end else if (busy_q) begin
        if (count_q <= 16'h0001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### design/fsc_status_regs.v
// status and configuration register set of the serial flash
`include "fsc_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module fsc_status_regs (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // decoded instruction from the command front end
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_data,
  // array engine status
  input wire array_op_done,
  // pins
  input wire write_guard_n,
  // readback for the status read instructions
  output reg [7:0] read_data_q,
  output wire cmd_accepted,
  // configuration out
  output wire [7:0] status_byte_one,
  output wire [7:0] status_byte_two,
  output wire [7:0] status_byte_three,
  output wire [2:0] protect_range,
  output wire protect_end_select,
  output wire granularity_select,
  output wire invert_protect_map,
  output wire [2:0] otp_lock,
  output wire four_lane_enable,
  output wire guard_pin_active,
  output wire pause_pin_active,
  output wire reset_pin_active,
  output wire [1:0] output_strength,
  output wire fast_precharge_mode,
  output wire paused_flag,
  output wire array_op_start
);
  // non-volatile images and volatile working copies
  reg [7:0] nv_one_q;
  reg [7:0] nv_two_q;
  reg [7:0] nv_three_q;
  reg [7:0] vol_one_q;
  reg [7:0] vol_two_q;
  reg [7:0] vol_three_q;
  reg [2:0] lock_q;
  reg wel_q;
  reg vwel_q;
  reg paused_q;
  reg array_busy_q;
  reg nv_pend_q;
  reg [7:0] pend_one_q;
  reg [7:0] pend_two_q;
  reg [7:0] pend_three_q;
  reg [1:0] pend_sel_q;
  wire timer_busy;
  wire timer_done;
  wire busy;
  wire is_status_read;
  wire is_wr;
  wire wr_nv;
  wire wr_vol;
  wire hw_locked;
  wire [1:0] wr_sel;

  // next values of the registers above
  reg [7:0] nv_one_d;
  reg [7:0] nv_two_d;
  reg [7:0] nv_three_d;
  reg [7:0] vol_one_d;
  reg [7:0] vol_two_d;
  reg [7:0] vol_three_d;
  reg [2:0] lock_d;
  reg wel_d;
  reg vwel_d;
  reg paused_d;
  reg array_busy_d;
  reg nv_pend_d;
  reg [7:0] pend_one_d;
  reg [7:0] pend_two_d;
  reg [7:0] pend_three_d;
  reg [1:0] pend_sel_d;
  reg [7:0] read_data_d;
  wire commit;

  function [7:0] merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask;
    begin
      merge = (old_v & ~mask) | (new_v & mask);
    end
  endfunction

  function is_array_cmd;
    input [7:0] c;
    begin
      is_array_cmd = (c == `FSC_CMD_PP) || (c == `FSC_CMD_SE) || (c == `FSC_CMD_BE) || (c == `FSC_CMD_CE);
    end
  endfunction

  fsc_busy_timer u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(cmd_accepted && wr_nv),
    .cycles(`FSC_NV_WRITE_CYC),
    .busy_q(timer_busy),
    .done_q(timer_done)
  );

  assign busy = timer_busy | array_busy_q | nv_pend_q;
  assign is_status_read = (cmd_code == `FSC_CMD_RDSR1) || (cmd_code == `FSC_CMD_RDSR2) ||
                          (cmd_code == `FSC_CMD_RDSR3);
  assign cmd_accepted = cmd_valid && (!busy || is_status_read);
  assign is_wr = (cmd_code == `FSC_CMD_WRSR1) || (cmd_code == `FSC_CMD_WRSR2) ||
                 (cmd_code == `FSC_CMD_WRSR3);
  assign wr_sel = (cmd_code == `FSC_CMD_WRSR1) ? 2'h0 : (cmd_code == `FSC_CMD_WRSR2) ? 2'h1 : 2'h2;
  // guard pin only counts while lanes two and three are not data
  assign hw_locked = vol_one_q[`FSC_B1_LOCKMODE] && !write_guard_n && !vol_two_q[`FSC_B2_QUAD];
  assign wr_vol = cmd_accepted && is_wr && vwel_q;
  assign wr_nv = cmd_accepted && is_wr && wel_q && !vwel_q;
  assign array_op_start = cmd_accepted && is_array_cmd(cmd_code) && wel_q;

  assign commit = timer_done && nv_pend_q;

  // command side: volatile enable, readback and suspend flag
  always @* begin
    vwel_d = vwel_q;
    read_data_d = read_data_q;
    paused_d = paused_q;
    if (cmd_accepted) begin
      // any other accepted command drops the volatile enable
      vwel_d = (cmd_code == `FSC_CMD_VWREN);
      case (cmd_code)
        `FSC_CMD_RDSR1: begin
          read_data_d = status_byte_one;
        end
        `FSC_CMD_RDSR2: begin
          read_data_d = status_byte_two;
        end
        `FSC_CMD_RDSR3: begin
          read_data_d = status_byte_three;
        end
        // suspend is refused while busy, so a taken one always sets the flag
        `FSC_CMD_SUSP: begin
          paused_d = 1'b1;
        end
        `FSC_CMD_RESUME: begin
          paused_d = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // write latch: later terms win where events stack
  always @* begin
    wel_d = wel_q;
    if (cmd_accepted && (cmd_code == `FSC_CMD_WREN)) begin
      wel_d = 1'b1;
    end
    if (cmd_accepted && (cmd_code == `FSC_CMD_WRDI)) begin
      wel_d = 1'b0;
    end
    if (!array_op_start && array_op_done) begin
      wel_d = 1'b0;
    end
    if (wr_nv) begin
      wel_d = 1'b1;
    end
    if (commit) begin
      wel_d = 1'b0;
    end
  end

  // array engine: busy from start until the engine reports done
  always @* begin
    array_busy_d = array_busy_q;
    if (array_op_start) begin
      array_busy_d = 1'b1;
    end else if (array_op_done) begin
      array_busy_d = 1'b0;
    end
  end

  // non-volatile write: data parked until the timer ends
  always @* begin
    nv_pend_d = nv_pend_q;
    pend_sel_d = pend_sel_q;
    pend_one_d = pend_one_q;
    pend_two_d = pend_two_q;
    pend_three_d = pend_three_q;
    if (wr_nv) begin
      nv_pend_d = 1'b1;
      pend_sel_d = wr_sel;
      pend_one_d = cmd_data;
      pend_two_d = cmd_data;
      pend_three_d = cmd_data;
    end
    if (commit) begin
      nv_pend_d = 1'b0;
    end
  end

  // byte one: volatile write at once, non-volatile at commit
  always @* begin
    nv_one_d = nv_one_q;
    vol_one_d = vol_one_q;
    if (wr_vol && (wr_sel == 2'h0) && !hw_locked) begin
      vol_one_d = merge(vol_one_q, cmd_data, `FSC_SR1_WMASK);
    end
    if (commit && (pend_sel_q == 2'h0) && !hw_locked) begin
      nv_one_d = merge(nv_one_q, pend_one_q, `FSC_SR1_WMASK);
      vol_one_d = merge(vol_one_q, pend_one_q, `FSC_SR1_WMASK);
    end
  end

  // byte two: lock bits only through the non-volatile path
  always @* begin
    nv_two_d = nv_two_q;
    vol_two_d = vol_two_q;
    lock_d = lock_q;
    if (wr_vol && (wr_sel == 2'h1) && !hw_locked) begin
      vol_two_d = merge(vol_two_q, cmd_data, `FSC_SR2_WMASK & ~`FSC_SR2_LOCK_MASK);
    end
    if (commit && (pend_sel_q == 2'h1) && !hw_locked) begin
      nv_two_d = merge(nv_two_q, pend_two_q, `FSC_SR2_WMASK & ~`FSC_SR2_LOCK_MASK);
      vol_two_d = merge(vol_two_q, pend_two_q, `FSC_SR2_WMASK & ~`FSC_SR2_LOCK_MASK);
      // or-in only: a programmed lock returns to zero only on sys_rst
      lock_d = lock_q | pend_two_q[5:3];
    end
  end

  // byte three: not guarded by the lock mode
  always @* begin
    nv_three_d = nv_three_q;
    vol_three_d = vol_three_q;
    if (wr_vol && (wr_sel == 2'h2)) begin
      vol_three_d = merge(vol_three_q, cmd_data, `FSC_SR3_WMASK);
    end
    if (commit && (pend_sel_q == 2'h2)) begin
      // strength bits have no non-volatile copy
      nv_three_d = merge(nv_three_q, pend_three_q, 8'h90);
      vol_three_d = merge(vol_three_q, pend_three_q, 8'h90);
    end
  end

  // one register stage for all the next values above
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      nv_one_q <= `FSC_RESET_VAL;
      nv_two_q <= `FSC_RESET_VAL;
      nv_three_q <= `FSC_RESET_VAL;
      vol_one_q <= `FSC_RESET_VAL;
      vol_two_q <= `FSC_RESET_VAL;
      vol_three_q <= `FSC_RESET_VAL;
      lock_q <= 3'h0;
      wel_q <= 1'b0;
      vwel_q <= 1'b0;
      paused_q <= 1'b0;
      array_busy_q <= 1'b0;
      nv_pend_q <= 1'b0;
      pend_one_q <= `FSC_RESET_VAL;
      pend_two_q <= `FSC_RESET_VAL;
      pend_three_q <= `FSC_RESET_VAL;
      pend_sel_q <= 2'h0;
      read_data_q <= `FSC_RESET_VAL;
    end else begin
      nv_one_q <= nv_one_d;
      nv_two_q <= nv_two_d;
      nv_three_q <= nv_three_d;
      vol_one_q <= vol_one_d;
      vol_two_q <= vol_two_d;
      vol_three_q <= vol_three_d;
      lock_q <= lock_d;
      wel_q <= wel_d;
      vwel_q <= vwel_d;
      paused_q <= paused_d;
      array_busy_q <= array_busy_d;
      nv_pend_q <= nv_pend_d;
      pend_one_q <= pend_one_d;
      pend_two_q <= pend_two_d;
      pend_three_q <= pend_three_d;
      pend_sel_q <= pend_sel_d;
      read_data_q <= read_data_d;
    end
  end

  // a write status command that carries no enable drops the volatile enable too
  assign status_byte_one = {vol_one_q[7:2], wel_q, busy};
  assign status_byte_two = {paused_q, vol_two_q[6], lock_q, 1'b0, vol_two_q[1], 1'b0};
  assign status_byte_three = {vol_three_q[7:4], 4'h0};
  assign protect_range = vol_one_q[4:2];
  assign protect_end_select = vol_one_q[`FSC_B1_ENDSEL];
  assign granularity_select = vol_one_q[`FSC_B1_GRAN];
  assign invert_protect_map = vol_two_q[`FSC_B2_INVERT];
  assign otp_lock = lock_q;
  assign four_lane_enable = vol_two_q[`FSC_B2_QUAD];
  assign guard_pin_active = !four_lane_enable;
  assign pause_pin_active = !four_lane_enable && !vol_three_q[`FSC_B3_PINFN];
  assign reset_pin_active = !four_lane_enable && vol_three_q[`FSC_B3_PINFN];
  assign output_strength = vol_three_q[6:5];
  assign fast_precharge_mode = vol_three_q[`FSC_B3_HFM];
  assign paused_flag = paused_q;
endmodule
`default_nettype wire

// ### dv/fsc_host_model.sv
// command front end model: issues decoded commands, answers array ops
`timescale 1ns/10ps
`default_nettype none
module fsc_host_model #(
  parameter int DONE_CYC = 30
) (
  // clock and device answers
  input wire logic clk_sys,
  input wire logic cmd_accepted,
  input wire logic array_op_start,
  // command and engine outputs
  output var logic cmd_valid,
  output var logic [7:0] cmd_code,
  output var logic [7:0] cmd_data,
  output var logic array_op_done
);
  int cnt = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 8'h00;
    array_op_done = 1'b0;
  end
  // one command, held through the sampling edge; caller sequences 50h or 06h before writes
  task automatic send(input logic [7:0] c, input logic [7:0] d, output logic a);
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    #1 a = cmd_accepted;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    // released lines must not keep showing the last opcode
    cmd_code = ~c;
    cmd_data = ~d;
    @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    array_op_done <= (cnt == 1);
    if (array_op_start) cnt <= DONE_CYC;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// ### dv/fsc_status_regs_sva.sv
// port assertions for the status register set
`include "fsc_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module fsc_status_regs_chk (
  // clock, reset, command
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_accepted,
  input wire logic array_op_start,
  // status and configuration
  input wire logic [7:0] status_byte_one,
  input wire logic [7:0] status_byte_two,
  input wire logic [7:0] status_byte_three,
  input wire logic paused_flag,
  input wire logic [2:0] otp_lock,
  input wire logic four_lane_enable,
  input wire logic guard_pin_active,
  input wire logic pause_pin_active,
  input wire logic reset_pin_active,
  input wire logic [1:0] output_strength,
  input wire logic fast_precharge_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence taken(logic [7:0] c);
    cmd_valid && cmd_accepted && cmd_code == c;
  endsequence
  sequence busy_other;
    status_byte_one[0] && cmd_valid && !(cmd_code inside {8'h05, 8'h35, 8'h15});
  endsequence
  busy_refuse_a: assert property (busy_other |-> !cmd_accepted)
    else $error("command taken while busy");
  wel_set_a: assert property (taken(`FSC_CMD_WREN) |=> status_byte_one[1])
    else $error("write enable did not arm latch");
  wel_clear_a: assert property (taken(`FSC_CMD_WRDI) |=> !status_byte_one[1])
    else $error("write disable left latch armed");
  paused_map_a: assert property (paused_flag == status_byte_two[7])
    else $error("paused flag not at byte two bit 7");
  quad_pins_a: assert property (four_lane_enable |-> !(guard_pin_active || pause_pin_active || reset_pin_active))
    else $error("pin function active in four lane mode");
  pin_fn_a: assert property (!four_lane_enable |-> reset_pin_active == status_byte_three[7] &&
                             pause_pin_active == !status_byte_three[7])
    else $error("pause or reset pin function wrong");
  strength_map_a: assert property ({output_strength, fast_precharge_mode} == status_byte_three[6:4])
    else $error("strength or fast mode not from byte three");
  lock_keep_a: assert property ((otp_lock & $past(otp_lock)) == $past(otp_lock))
    else $error("lock bit cleared");
  reserved_zero_a: assert property (status_byte_two[2] == 1'b0 && status_byte_two[0] == 1'b0 &&
                                    status_byte_three[3:0] == 4'h0)
    else $error("reserved bit reads one");
  busy_end_a: assert property ($fell(status_byte_one[0]) |-> !status_byte_one[1])
    else $error("latch still armed after operation");
  suspend_set_a: assert property (taken(`FSC_CMD_SUSP) |=> paused_flag)
    else $error("suspend did not set paused flag");
  resume_clear_a: assert property (taken(`FSC_CMD_RESUME) |=> !paused_flag)
    else $error("resume left paused flag set");
  start_latch_a: assert property (array_op_start |-> status_byte_one[1] && !status_byte_one[0])
    else $error("array operation started without latch or while busy");
endmodule
bind fsc_status_regs fsc_status_regs_chk u_chk (.*);
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the status register set
`include "fsc_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, sys_rst = 1'b1, write_guard_n = 1'b1, acc;
  logic cmd_valid, array_op_done, cmd_accepted, array_op_start, protect_end_select, granularity_select;
  logic invert_protect_map, four_lane_enable, guard_pin_active, pause_pin_active, reset_pin_active;
  logic fast_precharge_mode, paused_flag;
  logic [7:0] cmd_code, cmd_data, read_data_q, status_byte_one, status_byte_two, status_byte_three;
  logic [2:0] protect_range, otp_lock;
  logic [1:0] output_strength;
  int n_errors = 0, cmp_count = 0;
  fsc_status_regs DUT (.*);
  fsc_host_model host (.*);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    host.send(c, d, acc);
  endtask
  // volatile write: 50h directly ahead of the status write
  task automatic vwr(input logic [7:0] c, input logic [7:0] d);
    send(`FSC_CMD_VWREN, 8'h00);
    send(c, d);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2000 && status_byte_one[0] !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({7'h00, status_byte_one[0]}, 8'h00);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    chk(status_byte_one, 8'h00);
    chk(status_byte_two, 8'h00);
    chk({5'h00, guard_pin_active, pause_pin_active, reset_pin_active}, 8'h06);
    send(`FSC_CMD_WREN, 8'h00);
    chk(status_byte_one, 8'h02);
    send(`FSC_CMD_WRDI, 8'h00);
    chk(status_byte_one, 8'h00);
    send(`FSC_CMD_WREN, 8'h00);
    send(`FSC_CMD_WRSR1, 8'h1F);
    chk({7'h00, status_byte_one[0]}, 8'h01);
    send(`FSC_CMD_WREN, 8'h00);
    chk({7'h00, acc}, 8'h00);
    send(`FSC_CMD_RDSR1, 8'h00);
    chk({acc, 6'h00, read_data_q[0]}, 8'h81);
    wait_idle;
    chk(status_byte_one, 8'h1C);
    chk({5'h00, protect_range}, 8'h07);
    vwr(`FSC_CMD_WRSR1, 8'h60);
    chk({3'h0, granularity_select, protect_end_select, protect_range}, 8'h18);
    vwr(`FSC_CMD_WRSR2, 8'hFF);
    chk(status_byte_two, 8'h42);
    chk({4'h0, invert_protect_map, four_lane_enable, guard_pin_active, pause_pin_active}, 8'h0C);
    vwr(`FSC_CMD_WRSR3, 8'hFF);
    chk({output_strength, fast_precharge_mode, reset_pin_active, status_byte_three[3:0]}, 8'hE0);
    vwr(`FSC_CMD_WRSR2, 8'h00);
    chk({5'h00, guard_pin_active, pause_pin_active, reset_pin_active}, 8'h05);
    send(`FSC_CMD_RDSR3, 8'h00);
    chk(read_data_q, 8'hF0);
    // lock bits only through the long write, and they stick
    send(`FSC_CMD_WREN, 8'h00);
    send(`FSC_CMD_WRSR2, 8'h38);
    wait_idle;
    chk({5'h00, otp_lock}, 8'h07);
    send(`FSC_CMD_WREN, 8'h00);
    send(`FSC_CMD_WRSR2, 8'h00);
    wait_idle;
    chk({5'h00, otp_lock}, 8'h07);
    send(`FSC_CMD_RDSR2, 8'h00);
    chk(read_data_q, 8'h38);
    vwr(`FSC_CMD_WRSR1, 8'h80);
    write_guard_n = 1'b0;
    vwr(`FSC_CMD_WRSR1, 8'h20);
    vwr(`FSC_CMD_WRSR2, 8'h40);
    chk(status_byte_one, 8'h80);
    chk(status_byte_two, 8'h38);
    write_guard_n = 1'b1;
    vwr(`FSC_CMD_WRSR1, 8'h00);
    chk(status_byte_one, 8'h00);
    send(`FSC_CMD_WREN, 8'h00);
    send(`FSC_CMD_PP, 8'h00);
    chk({7'h00, status_byte_one[0]}, 8'h01);
    wait_idle;
    chk(status_byte_one, 8'h00);
    send(`FSC_CMD_SUSP, 8'h00);
    chk({paused_flag, status_byte_two[7], 6'h00}, 8'hC0);
    send(`FSC_CMD_RESUME, 8'h00);
    chk({7'h00, paused_flag}, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
